// ===== common/mmpc_pkg.sv
// Shared constants and types for the modem mode and power controller
package mmpc_pkg;

    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;

    // Times in their printed units
    localparam int unsigned FAULT_BLINK_MS = 250;
    localparam int unsigned FAULT_REBOOT_MS = 5000;
    localparam int unsigned WAKE_MIN_US    = 10;
    localparam int unsigned WAKE_OK_MS     = 30;
    localparam int unsigned PAUSE_CAP_MS   = 170;
    localparam int unsigned MARG_ADD_MS    = 60;
    localparam int unsigned OVERLAP_ADD_MS = 100;

    // Derived cycle counts
    localparam int unsigned FAULT_BLINK_CYC = FAULT_BLINK_MS * CYC_PER_MS;
    localparam int unsigned WAKE_OK_CYC     = WAKE_OK_MS * CYC_PER_MS;
    localparam int unsigned PAUSE_CAP_CYC   = PAUSE_CAP_MS * CYC_PER_MS;
    localparam int unsigned WAKE_MIN_CYC    = WAKE_MIN_US * CYC_PER_US;

    localparam int unsigned STUDY_PKTS      = 4;
    localparam int unsigned RESTUDY_CYCLES  = 100;
    localparam int unsigned MARG_DIV_SHIFT  = 3;
    localparam int unsigned FAULT_BLINKS    = FAULT_REBOOT_MS / FAULT_BLINK_MS;

    localparam logic [7:0]  PAUSE_CHR_MIN   = 8'h03;
    localparam logic [7:0]  PAUSE_CHR_MAX   = 8'hFF;
    localparam logic [7:0]  PAUSE_CHR_RST   = 8'h03;
    localparam logic [3:0]  BITS_8N1        = 4'hA;

    localparam int unsigned MS_W            = 16;
    localparam logic [15:0] MS_MAX          = 16'hFFFF;

    typedef enum logic [5:0] {
        MMPC_OFF   = 6'b00_0001,
        MMPC_ON    = 6'b00_0010,
        MMPC_SLEEP = 6'b00_0100,
        MMPC_WAKE  = 6'b00_1000,
        MMPC_FAULT = 6'b01_0000,
        MMPC_BOOT  = 6'b10_0000
    } mmpc_mode_e;

    // Serial-line framing settings
    typedef struct packed {
        logic [15:0] bit_cyc;     // Clock cycles per serial bit
        logic [3:0]  chr_bits;    // Bits per character frame
        logic [7:0]  pause_chr;   // Pause length in characters
    } mmpc_ser_cfg_s;

    // Pause detector results
    typedef struct packed {
        logic pause;              // Line idle long enough (level)
        logic cmd_ok;             // Character after a pause starts here (pulse)
        logic edge_seen;          // Any line transition (pulse)
    } mmpc_pause_s;

endpackage

// ===== design/mmpc_pause_det.sv
// Serial-line pause detector with character-time conversion and time cap
`timescale 1ns/1ps
`default_nettype none
module mmpc_pause_det (
    input  wire logic                   clk,      // System clock
    input  wire logic                   rstn,     // Async reset, active low
    input  wire logic                   clr,      // Clear volatile state
    input  wire logic                   line,     // Host serial transmit line
    input  wire mmpc_pkg::mmpc_ser_cfg_s cfg,     // Framing settings
    output mmpc_pkg::mmpc_pause_s       st        // Pause results
);
    logic        line_r;
    logic [31:0] idle_cnt_r;
    logic        pause_r;
    logic        gap_r;
    logic [7:0]  chr_eff;
    logic [31:0] limit;

    always_comb begin
        chr_eff = cfg.pause_chr;
        if (chr_eff < mmpc_pkg::PAUSE_CHR_MIN) begin
            chr_eff = mmpc_pkg::PAUSE_CHR_MIN; // R20
        end
        limit = 32'(cfg.bit_cyc) * 32'(cfg.chr_bits) * 32'(chr_eff); // R22
        if (limit > 32'(mmpc_pkg::PAUSE_CAP_CYC)) begin
            limit = 32'(mmpc_pkg::PAUSE_CAP_CYC); // R21
        end
    end

    wire logic edge_now = (line ^ line_r);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_r <= 1'b1;
        end else begin
            line_r <= line;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            idle_cnt_r <= 32'h0000_0000;
            pause_r    <= 1'b0;
        end else if (clr || edge_now) begin
            idle_cnt_r <= 32'h0000_0000;
            pause_r    <= 1'b0;
        end else if (idle_cnt_r < limit) begin
            idle_cnt_r <= idle_cnt_r + 32'h0000_0001;
        end else begin
            pause_r <= 1'b1; // R16
        end
    end

    // Remembers that the last idle gap qualified, until the next edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap_r <= 1'b0;
        end else if (clr) begin
            gap_r <= 1'b0;
        end else if (edge_now) begin
            gap_r <= 1'b0;
        end else if (pause_r) begin
            gap_r <= 1'b1;
        end
    end

    assign st.pause     = pause_r;
    assign st.cmd_ok    = edge_now & gap_r; // R18 R19
    assign st.edge_seen = edge_now;
endmodule
`default_nettype wire

// ===== design/mmpc_interval.sv
// Power-save interval study and sleep schedule
`timescale 1ns/1ps
`default_nettype none
module mmpc_interval (
    input  wire logic        clk,          // System clock
    input  wire logic        rstn,         // Async reset, active low
    input  wire logic        clr,          // Clear volatile state
    input  wire logic        enable,       // Power save enabled
    input  wire logic        ms_tick,      // One-cycle 1 ms enable
    input  wire logic        pkt_ok,       // Packet received successfully
    input  wire logic [15:0] tx_ms,        // Original message air time
    output logic             rx_on,        // Receiver requested on
    output logic             study_done,   // Interval study complete
    output logic             pkt_lost,     // Expected packet missed (pulse)
    output logic [15:0]      tmin_ms,      // Measured minimum interval
    output logic [15:0]      sleep_ms      // Computed sleep length
);
    logic [15:0] tmin_r;
    logic [15:0] since_r;
    logic [2:0]  nstudy_r;
    logic [6:0]  ncyc_r;
    logic        have_r;
    logic        lost_r;
    logic [15:0] marg;
    logic [15:0] overlap;
    logic [15:0] slp;
    logic [16:0] slot_max;
    logic        done;

    always_comb begin
        marg     = (tmin_r >> mmpc_pkg::MARG_DIV_SHIFT) + 16'(mmpc_pkg::MARG_ADD_MS); // R11
        overlap  = marg + 16'(mmpc_pkg::OVERLAP_ADD_MS); // R14
        slot_max = {1'b0, tmin_r} + {1'b0, overlap}; // R14
        if (tmin_r > marg + tx_ms) begin
            slp = tmin_r - marg - tx_ms; // R12
        end else begin
            slp = 16'h0000;
        end
    end

    assign done = (nstudy_r == 3'(mmpc_pkg::STUDY_PKTS));
    wire logic miss = enable && done && ({1'b0, since_r} > slot_max); // R13
    wire logic restart = miss || (ncyc_r == 7'(mmpc_pkg::RESTUDY_CYCLES)); // R13

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            since_r <= 16'h0000;
        end else if (clr || !enable || pkt_ok || miss) begin
            since_r <= 16'h0000;
        end else if (ms_tick && since_r != mmpc_pkg::MS_MAX) begin
            since_r <= since_r + 16'h0001;
        end
    end

    // Minimum interval, refreshed on every good packet
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tmin_r   <= mmpc_pkg::MS_MAX;
            have_r   <= 1'b0;
            nstudy_r <= 3'h0;
        end else if (clr || !enable || restart) begin
            tmin_r   <= mmpc_pkg::MS_MAX;
            have_r   <= 1'b0;
            nstudy_r <= 3'h0;
        end else if (pkt_ok) begin
            have_r <= 1'b1;
            if (have_r && since_r < tmin_r) begin
                tmin_r <= since_r; // R9 R10
            end
            if (!done) begin
                nstudy_r <= nstudy_r + 3'h1; // R9
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ncyc_r <= 7'h00;
        end else if (clr || !enable || restart || !done) begin
            ncyc_r <= 7'h00;
        end else if (pkt_ok) begin
            ncyc_r <= ncyc_r + 7'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lost_r <= 1'b0;
        end else begin
            lost_r <= miss;
        end
    end

    // Sleep from last packet for slp ms, then listen through the slot
    assign rx_on      = !enable || !done || (since_r >= slp); // R23
    assign study_done = done;
    assign pkt_lost   = lost_r;
    assign tmin_ms    = tmin_r;
    assign sleep_ms   = slp;
endmodule
`default_nettype wire

// ===== design/mmpc_ctrl.sv
// Mode and power controller top for the serial radio modem
// Notes on behaviour
// R1: Fault enters recovery: status pin toggles each 250 ms, reboot after 5 s.
// R2: In recovery, radio transmit and receive blocked; fault codes readable.
// R3: Enable input high turns device on; low shuts it down.
// R4: Off state powers down extras and clears all volatile settings.
// R5: Light sleep turns radio off, serial logic stays up watching the line.
// R6: Any level change on host transmit line wakes from light sleep.
// R7: After waking, OK is signalled within about 30 ms.
// R8: Once awake, stay powered until the next sleep command.
// R9: Power save studies four good packets, keeping shortest interval.
// R10: Minimum interval refreshed after every good packet.
// R11: Margin is minimum interval over 8 plus 60 ms.
// R12: Sleep is minimum interval minus margin minus message air time.
// R13: Study restarts after 100 cycles or a missed receive window.
// R14: Window spans minimum minus margin to minimum plus margin plus 100 ms.
// R15: Restart command shuts everything down then reboots; core_pwr_en stays on through the one-cycle boot state.
// R16: Pause is no line transitions for the configured pause length.
// R17: Transmission ends only with empty buffer and a detected pause.
// R18: Configuration command accepted only when a pause precedes it.
// R19: Address start character recognised only after a pause.
// R20: Pause length 3 to 255 characters, default 3.
// R21: Pause time capped at 170 ms.
// R22: Pause characters converted to time from frame bits and bit rate.
// R23: Until study completes, receiver stays on, no sleeping.
`timescale 1ns/1ps
`default_nettype none
module mmpc_ctrl (
    input  wire logic        clk,              // System clock, 125 MHz
    input  wire logic        rstn,             // Async reset, active low
    input  wire logic        module_enable_in, // Host enable level
    input  wire logic        host_serial_tx_line, // Host serial transmit line
    input  wire logic        fault_in,         // Fault detected (pulse)
    input  wire logic [7:0]  fault_code_in,    // Code of detected fault
    input  wire logic        sleep_cmd,        // Light sleep command (pulse)
    input  wire logic        restart_cmd,      // Restart command (pulse)
    input  wire logic        psave_en,         // Power save enable level
    input  wire logic        pkt_ok,           // Good packet received (pulse)
    input  wire logic [15:0] tx_ms,            // Message air time in ms
    input  wire logic        tx_active,        // Radio transmitting level
    input  wire logic        tx_buf_empty,     // Transmit buffer empty
    input  wire logic [15:0] bit_cyc,          // Clock cycles per serial bit
    input  wire logic [3:0]  chr_bits,         // Bits per character
    input  wire logic        pause_wr,         // Write pause length (pulse)
    input  wire logic [7:0]  pause_wdata,      // New pause length
    input  wire logic        config_command,   // Command string started (pulse)
    input  wire logic        addr_chr,         // Address start char seen (pulse)
    output logic [5:0]       mode,             // Current one-hot mode
    output logic             core_pwr_en,      // Non-essential power on
    output logic             radio_pwr_en,     // Radio section powered
    output logic             serial_pwr_en,    // Serial logic powered
    output logic             rx_en,            // Receiver allowed
    output logic             tx_en,            // Transmitter allowed
    output logic             tx_stop,          // End transmission (level)
    output logic             cmd_accept,       // Command accepted (pulse)
    output logic             addr_accept,      // Address start accepted (pulse)
    output logic             ok_resp,          // Send OK after wake (pulse)
    output logic             stat_pin,         // Status indicator
    output logic             fault_valid,      // Fault code readable
    output logic [7:0]       fault_code,       // Stored fault code
    output logic             reboot,           // Processor reboot (pulse)
    output logic [7:0]       pause_chr,        // Current pause length
    output logic             pause_det,        // Pause detected level
    output logic             pkt_lost,         // Expected packet lost (pulse)
    output logic [15:0]      tmin_ms,          // Measured minimum interval
    output logic [15:0]      sleep_ms          // Computed sleep length
);
    mmpc_pkg::mmpc_mode_e    mode_r;
    mmpc_pkg::mmpc_mode_e    mode_nxt;
    mmpc_pkg::mmpc_ser_cfg_s cfg;
    mmpc_pkg::mmpc_pause_s   pst;

    logic [31:0] tmr_r;
    logic [16:0] ms_cnt_r;
    logic        ms_tick;
    logic [4:0]  blink_r;
    logic        stat_r;
    logic [7:0]  pause_chr_r;
    logic [7:0]  fcode_r;
    logic        fvalid_r;
    logic        ok_r;
    logic        reboot_r;
    logic        stop_r;
    logic        cmd_r;
    logic        addr_r;
    logic        study_done;
    logic        ps_rx_on;
    logic        clr;

    wire logic in_off   = (mode_r == mmpc_pkg::MMPC_OFF);
    wire logic in_fault = (mode_r == mmpc_pkg::MMPC_FAULT);
    wire logic in_sleep = (mode_r == mmpc_pkg::MMPC_SLEEP);
    wire logic in_boot  = (mode_r == mmpc_pkg::MMPC_BOOT);

    assign clr = in_off || in_boot; // R4 R15

    // Millisecond enable for the interval logic
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ms_cnt_r <= 17'h0_0000;
        end else if (ms_cnt_r == 17'(mmpc_pkg::CYC_PER_MS - 1)) begin
            ms_cnt_r <= 17'h0_0000;
        end else begin
            ms_cnt_r <= ms_cnt_r + 17'h0_0001;
        end
    end
    assign ms_tick = (ms_cnt_r == 17'(mmpc_pkg::CYC_PER_MS - 1));

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            mmpc_pkg::MMPC_OFF: begin
                if (module_enable_in) begin
                    mode_nxt = mmpc_pkg::MMPC_ON; // R3
                end
            end
            mmpc_pkg::MMPC_ON: begin
                if (fault_in) begin
                    mode_nxt = mmpc_pkg::MMPC_FAULT; // R1
                end else if (restart_cmd) begin
                    mode_nxt = mmpc_pkg::MMPC_BOOT; // R15
                end else if (sleep_cmd) begin
                    mode_nxt = mmpc_pkg::MMPC_SLEEP; // R8
                end
            end
            mmpc_pkg::MMPC_SLEEP: begin
                if (pst.edge_seen) begin
                    mode_nxt = mmpc_pkg::MMPC_WAKE; // R6
                end
            end
            mmpc_pkg::MMPC_WAKE: begin
                if (tmr_r == 32'(mmpc_pkg::WAKE_OK_CYC - 1)) begin
                    mode_nxt = mmpc_pkg::MMPC_ON; // R7
                end
            end
            mmpc_pkg::MMPC_FAULT: begin
                if (blink_r == 5'(mmpc_pkg::FAULT_BLINKS - 1) &&
                    tmr_r == 32'(mmpc_pkg::FAULT_BLINK_CYC - 1)) begin
                    mode_nxt = mmpc_pkg::MMPC_BOOT; // R1
                end
            end
            mmpc_pkg::MMPC_BOOT: begin
                mode_nxt = mmpc_pkg::MMPC_ON; // R15
            end
            default: begin
                mode_nxt = mmpc_pkg::MMPC_OFF;
            end
        endcase
        if (!module_enable_in) begin
            mode_nxt = mmpc_pkg::MMPC_OFF; // R3
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= mmpc_pkg::MMPC_OFF;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // Mode timer, restarted on every mode change
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tmr_r   <= 32'h0000_0000;
            blink_r <= 5'h00;
        end else if (mode_nxt != mode_r) begin
            tmr_r   <= 32'h0000_0000;
            blink_r <= 5'h00;
        end else if (tmr_r == 32'(mmpc_pkg::FAULT_BLINK_CYC - 1) && in_fault) begin
            tmr_r   <= 32'h0000_0000;
            blink_r <= blink_r + 5'h01;
        end else begin
            tmr_r <= tmr_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat_r <= 1'b0;
        end else if (!in_fault) begin
            stat_r <= 1'b0;
        end else if (tmr_r == 32'(mmpc_pkg::FAULT_BLINK_CYC - 1)) begin
            stat_r <= ~stat_r; // R1
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fcode_r  <= 8'h00;
            fvalid_r <= 1'b0;
        end else if (in_off) begin
            fcode_r  <= 8'h00;
            fvalid_r <= 1'b0;
        end else if (fault_in && mode_r == mmpc_pkg::MMPC_ON) begin
            fcode_r  <= fault_code_in;
            fvalid_r <= 1'b1; // R2
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pause_chr_r <= mmpc_pkg::PAUSE_CHR_RST;
        end else if (in_off) begin
            pause_chr_r <= mmpc_pkg::PAUSE_CHR_RST; // R4
        end else if (pause_wr && pause_wdata >= mmpc_pkg::PAUSE_CHR_MIN) begin
            pause_chr_r <= pause_wdata; // R20
        end
    end

    always_comb begin
        cfg.bit_cyc   = bit_cyc;
        cfg.chr_bits  = (chr_bits == 4'h0) ? mmpc_pkg::BITS_8N1 : chr_bits; // R22
        cfg.pause_chr = pause_chr_r;
    end

    mmpc_pause_det u_pause (
        .clk  (clk),
        .rstn (rstn),
        .clr  (clr),
        .line (host_serial_tx_line),
        .cfg  (cfg),
        .st   (pst)
    );

    mmpc_interval u_intv (
        .clk        (clk),
        .rstn       (rstn),
        .clr        (clr),
        .enable     (psave_en && mode_r == mmpc_pkg::MMPC_ON),
        .ms_tick    (ms_tick),
        .pkt_ok     (pkt_ok),
        .tx_ms      (tx_ms),
        .rx_on      (ps_rx_on),
        .study_done (study_done),
        .pkt_lost   (pkt_lost),
        .tmin_ms    (tmin_ms),
        .sleep_ms   (sleep_ms)
    );

    // Event outputs registered
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ok_r     <= 1'b0;
            reboot_r <= 1'b0;
            stop_r   <= 1'b0;
            cmd_r    <= 1'b0;
            addr_r   <= 1'b0;
        end else begin
            ok_r     <= (mode_r == mmpc_pkg::MMPC_WAKE) &&
                        (mode_nxt == mmpc_pkg::MMPC_ON); // R7
            reboot_r <= in_boot; // R1 R15
            stop_r   <= tx_active && tx_buf_empty && pst.pause; // R17
            cmd_r    <= config_command && pst.cmd_ok && !in_fault; // R18
            addr_r   <= addr_chr && pst.cmd_ok; // R19
        end
    end

    assign mode          = mode_r;
    assign core_pwr_en   = !in_off; // R4
    assign radio_pwr_en  = (mode_r == mmpc_pkg::MMPC_ON) ||
                           (mode_r == mmpc_pkg::MMPC_WAKE); // R5
    assign serial_pwr_en = !in_off && !in_boot; // R5
    assign rx_en         = (mode_r == mmpc_pkg::MMPC_ON) && ps_rx_on; // R2 R23
    assign tx_en         = (mode_r == mmpc_pkg::MMPC_ON); // R2
    assign tx_stop       = stop_r;
    assign cmd_accept    = cmd_r;
    assign addr_accept   = addr_r;
    assign ok_resp       = ok_r;
    assign stat_pin      = stat_r;
    assign fault_valid   = fvalid_r && in_fault; // R2
    assign fault_code    = fcode_r;
    assign reboot        = reboot_r;
    assign pause_chr     = pause_chr_r;
    assign pause_det     = pst.pause;
    // Keep the unused study flag tied to a dummy wire
    wire logic unused_ok = study_done;
endmodule
`default_nettype wire

// ===== verif/mmpc_host_model.sv
// Host terminal model
`timescale 1ns/1ps
`default_nettype none
module mmpc_host_model (
    input  wire logic clk,    // Clock
    output var logic  line,   // Serial line, idles high
    output var logic  enable  // Enable level
);
    initial begin
        line = 1'b1;
        enable = 1'b0;
    end
    task automatic toggle();
        @(posedge clk);
        line <= ~line;
    endtask
    task automatic set_en(input logic v);
        @(posedge clk);
        enable <= v;
    endtask
endmodule
`default_nettype wire

// ===== verif/mmpc_ctrl_monitor.sv
// Port checks for the mode controller
`timescale 1ns/1ps
`default_nettype none
module mmpc_ctrl_monitor (
    input wire logic       clk,                 // Clock
    input wire logic       rstn,                // Reset, low
    input wire logic       module_enable_in,    // Enable
    input wire logic       host_serial_tx_line, // Line
    input wire logic       fault_in,            // Fault
    input wire logic       restart_cmd,         // Restart
    input wire logic       tx_buf_empty,        // Empty
    input wire logic       config_command,      // Command
    input wire logic [5:0] mode,                // Mode
    input wire logic       core_pwr_en,         // Core power
    input wire logic       radio_pwr_en,        // Radio power
    input wire logic       serial_pwr_en,       // Serial power
    input wire logic       rx_en,               // Receive
    input wire logic       tx_en,               // Transmit
    input wire logic       tx_stop,             // Stop
    input wire logic       cmd_accept,          // Accept
    input wire logic       stat_pin,            // Status
    input wire logic       reboot,              // Reboot
    input wire logic [7:0] pause_chr,           // Pause length
    input wire logic       pause_det            // Pause
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    enable_off_a: assert property (!module_enable_in |=> mode == 6'h01)
        else $error("not off");
    off_power_a: assert property (mode == 6'h01 |-> !core_pwr_en && !radio_pwr_en)
        else $error("power on");
    fault_block_a: assert property (mode == 6'h10 |-> !rx_en && !tx_en)
        else $error("radio on");
    sleep_power_a: assert property (mode == 6'h04 |-> !radio_pwr_en && serial_pwr_en)
        else $error("sleep power");
    wake_edge_a: assert property (mode == 6'h04 && module_enable_in
        && $changed(host_serial_tx_line) |-> ##[1:3] mode == 6'h08)
        else $error("no wake");
    restart_boot_a: assert property (mode == 6'h02 && module_enable_in && restart_cmd
        && !fault_in |=> mode == 6'h20 ##1 reboot)
        else $error("no reboot");
    stop_pause_a: assert property (tx_stop |-> $past(tx_buf_empty && pause_det))
        else $error("early stop");
    cmd_cause_a: assert property (cmd_accept |-> $past(config_command))
        else $error("stray accept");
    pause_floor_a: assert property (pause_chr >= mmpc_pkg::PAUSE_CHR_MIN)
        else $error("pause low");
    stat_idle_a: assert property (mode != 6'h10 && $past(mode) != 6'h10 |-> !stat_pin)
        else $error("status busy");
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Bench for the mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [5:0] F = 6'h20, S = 6'h10, RS = 6'h08, C = 6'h04, A = 6'h02, W = 6'h01;
    logic clk = 1'b0, rstn = 1'b0, tx_active = 1'b1, tx_buf_empty = 1'b0;
    logic [5:0] req = 6'h00;
    logic [7:0] fault_code_in = 8'h00, pause_wdata = 8'h00;
    logic psave_en = 1'b0, pkt_ok = 1'b0;
    logic [15:0] bit_cyc = 16'h2;
    logic [3:0] chr_bits = 4'h0;
    logic fault_in, sleep_cmd, restart_cmd, config_command, addr_chr, pause_wr;
    logic module_enable_in, host_serial_tx_line, core_pwr_en, radio_pwr_en, serial_pwr_en;
    logic rx_en, tx_en, tx_stop, cmd_accept, addr_accept, ok_resp, stat_pin, fault_valid;
    logic reboot, pause_det, pkt_lost;
    logic [5:0] mode;
    logic [7:0] fault_code, pause_chr;
    logic [15:0] tmin_ms, sleep_ms;
    int n_errors, n_tests, n_cmd, n_addr, n_stop, n_boot;
    assign {fault_in, sleep_cmd, restart_cmd, config_command, addr_chr, pause_wr} = req;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        n_cmd <= n_cmd + int'(cmd_accept);
        n_addr <= n_addr + int'(addr_accept);
        n_stop <= n_stop + int'(tx_stop);
        n_boot <= n_boot + int'(reboot);
    end
    mmpc_host_model u_mmpc_host_model (.clk, .line(host_serial_tx_line),
        .enable(module_enable_in));
    mmpc_ctrl u_mmpc_ctrl (.clk, .rstn, .module_enable_in, .host_serial_tx_line, .fault_in,
        .fault_code_in, .sleep_cmd, .restart_cmd, .psave_en, .pkt_ok,
        .tx_ms(16'h0), .tx_active, .tx_buf_empty, .bit_cyc, .chr_bits, .pause_wr,
        .pause_wdata, .config_command, .addr_chr, .mode, .core_pwr_en, .radio_pwr_en,
        .serial_pwr_en, .rx_en, .tx_en, .tx_stop, .cmd_accept, .addr_accept, .ok_resp,
        .stat_pin, .fault_valid, .fault_code, .reboot, .pause_chr, .pause_det, .pkt_lost,
        .tmin_ms, .sleep_ms);
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        req <= m;
        @(posedge clk);
        req <= 6'h00;
    endtask
    task automatic pwr(input logic [7:0] v);
        @(posedge clk);
        pause_wdata <= v;
        pulse(W);
        cyc(2);
    endtask
    task automatic close_out();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        $display("timeout");
        close_out();
    end
    initial begin
        u_mmpc_host_model.set_en(1'b1);
        cyc(12);
        chk("mode", 16'h1, 16'(mode));
        chk("pause_chr", 16'h3, 16'(pause_chr));
        chk("tmin_ms", 16'hFFFF, tmin_ms);
        @(posedge clk);
        rstn <= 1'b1;
        cyc(3);
        chk("mode", 16'h2, 16'(mode));
        $display("reset done");
        for (int k = 0; k < 2; k++) begin
            pwr(8'h02 + 8'(3 * k));
            chk("pause_chr", 16'(3 + 2 * k), 16'(pause_chr));
            u_mmpc_host_model.toggle();
            cyc(55 + 40 * k);
            chk("pause_det", 16'h0, 16'(pause_det));
            cyc(10);
            chk("pause_det", 16'h1, 16'(pause_det));
        end
        $display("pause done");
        for (int k = 0; k < 2; k++) begin
            fork
                u_mmpc_host_model.toggle();
                pulse(k == 0 ? C : A);
            join
            cyc(4);
            u_mmpc_host_model.toggle();
            pulse(k == 0 ? C : A);
            cyc(4);
            chk(k == 0 ? "cmd_accept" : "addr_accept", 16'h1, 16'(k == 0 ? n_cmd : n_addr));
            cyc(110);
        end
        chk("tx_stop", 16'h0, 16'(n_stop));
        @(posedge clk);
        tx_buf_empty <= 1'b1;
        cyc(4);
        chk("tx_stop", 16'h1, 16'(n_stop > 0));
        @(posedge clk);
        tx_active <= 1'b0;
        $display("framing done");
        pulse(S);
        cyc(2);
        chk("mode", 16'h4, 16'(mode));
        chk("radio_pwr", 16'h0, 16'(radio_pwr_en));
        chk("serial_pwr", 16'h1, 16'(serial_pwr_en));
        u_mmpc_host_model.toggle();
        cyc(3);
        chk("mode", 16'h8, 16'(mode));
        u_mmpc_host_model.set_en(1'b0);
        cyc(2);
        chk("core_pwr", 16'h0, 16'(core_pwr_en));
        chk("pause_chr", 16'h3, 16'(pause_chr));
        u_mmpc_host_model.set_en(1'b1);
        cyc(3);
        pulse(RS);
        cyc(4);
        chk("reboot", 16'h1, 16'(n_boot));
        chk("mode", 16'h2, 16'(mode));
        repeat (4) @(posedge clk) {psave_en, pkt_ok} <= {1'b1, ~pkt_ok};
        cyc(2);
        chk("tmin_ms", 16'h0, tmin_ms);
        chk("rx_en", 16'h1, 16'(rx_en));
        $display("sleep done");
        @(posedge clk);
        fault_code_in <= 8'h5A;
        pulse(F);
        cyc(2);
        chk("mode", 16'h10, 16'(mode));
        chk("rx_tx", 16'h0, 16'({rx_en, tx_en}));
        chk("fault_valid", 16'h1, 16'(fault_valid));
        chk("fault_code", 16'h5A, 16'(fault_code));
        u_mmpc_host_model.set_en(1'b0);
        cyc(2);
        chk("mode", 16'h1, 16'(mode));
        $display("fault done");
        close_out();
    end
endmodule
bind mmpc_ctrl mmpc_ctrl_monitor u_mon (.*);
`default_nettype wire
